/* hdl/dsz_core.sv */
`timescale 1ns/100ps
`default_nettype none

module dsz_core (
	input wire logic i_mclk, // core clock, 200 MHz
	input wire logic i_rst_n, // sync reset, active low
	input wire logic i_issue, // decoded instruction valid
	input wire dsz_pkg::dsz_op_t i_op, // which skip flavour
	input wire logic [dsz_pkg::FADDR_W-1:0] i_faddr, // operand f
	input wire logic i_dest, // operand d
	input wire logic i_bank_sel, // operand a
	input wire logic [dsz_pkg::BANK_W-1:0] i_bank_pointer, // bank reg
	input wire logic [dsz_pkg::DATA_W-1:0] i_mem_rdata, // read data
	output logic o_ready, // may take an issue
	output logic o_mem_rd_en, // data memory read strobe
	output logic [dsz_pkg::MADDR_W-1:0] o_mem_addr, // data address
	output logic o_mem_wr_en, // data memory write strobe
	output logic o_acc_wr_en, // accumulator write strobe
	output logic [dsz_pkg::DATA_W-1:0] o_wdata, // decremented value
	output logic o_squash, // discard the prefetched instruction
	output logic o_idle_slot, // idle_slot executing
	output logic o_done // instruction retires
);
	import dsz_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	dsz_state_t state_r; // sequence state
	dsz_state_t state_nxt; // next sequence state
	dsz_op_t op_r; // latched flavour
	logic dest_r; // latched destination bit
	logic [MADDR_W-1:0] addr_r; // latched full address
	logic [DATA_W-1:0] wdata_r; // latched result
	logic zero_r; // latched zero flag
	logic [DATA_W-1:0] dec_value; // datapath result
	logic dec_zero; // datapath zero flag
	logic take; // issue accepted this cycle
	logic skip; // squash decision in write cycle

	// ----------------------------------------------------------------
	// address formation
	// ----------------------------------------------------------------
	// pick the bank from the bank operand bit
	function automatic logic [MADDR_W-1:0] form_addr(
		input logic bank_sel,
		input logic [BANK_W-1:0] bank_pointer,
		input logic [FADDR_W-1:0] faddr
	);
		if (bank_sel == BANK_SHARED) begin
			form_addr = {SHARED_BANK, faddr}; // see RULE5
		end else begin
			form_addr = {bank_pointer, faddr}; // see RULE6
		end
	endfunction

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	dsz_dec_unit u_dec (
		.i_value(i_mem_rdata),
		.o_result(dec_value),
		.o_zero(dec_zero)
	);

	// ----------------------------------------------------------------
	// handshake and strobes
	// ----------------------------------------------------------------
	// strobes decoded straight from state
	always_comb begin
		o_ready = (state_r == ST_IDLE);
		take = i_issue && o_ready;
		o_mem_rd_en = (state_r == ST_READ); // see RULE1
		// zero flavour squashes on zero, the other on nonzero
		if (op_r == OP_DEC_SKIP_ZERO) begin
			skip = zero_r; // see RULE4
		end else begin
			skip = !zero_r; // see RULE7
		end
		o_mem_wr_en = (state_r == ST_WRITE) && (dest_r == DEST_FILE); // see RULE3
		o_acc_wr_en = (state_r == ST_WRITE) && (dest_r == DEST_ACC); // see RULE2
		o_squash = (state_r == ST_WRITE) && skip; // see RULE4
		o_idle_slot = (state_r == ST_SKIP); // see RULE4
		o_done = ((state_r == ST_WRITE) && !skip) || (state_r == ST_SKIP);
		o_mem_addr = addr_r;
		o_wdata = wdata_r;
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	// next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (take) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				state_nxt = ST_EXEC;
			end
			ST_EXEC: begin
				state_nxt = ST_WRITE;
			end
			ST_WRITE: begin
				// fourth cycle only when the fetch is discarded
				if (skip) begin
					state_nxt = ST_SKIP; // see RULE4
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			ST_SKIP: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// operand capture on issue
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			op_r <= OP_DEC_SKIP_ZERO;
			dest_r <= DEST_FILE;
			addr_r <= '0;
		end else if (take) begin
			op_r <= i_op;
			dest_r <= i_dest;
			addr_r <= form_addr(i_bank_sel, i_bank_pointer, i_faddr);
		end
	end

	// result capture when read data returns
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			wdata_r <= ZERO_BYTE;
			zero_r <= 1'b0;
		end else if (state_r == ST_EXEC) begin
			wdata_r <= dec_value; // see RULE1
			zero_r <= dec_zero;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	AST_READ_FOLLOWS_ISSUE: assert property ( // see RULE1
		take |=> o_mem_rd_en ##1 !o_mem_rd_en
	) else $error("read strobe not one cycle after issue");

	AST_DEC_RESULT: assert property ( // see RULE1
		(state_r == ST_EXEC) |=> (o_wdata == $past(i_mem_rdata) - DEC_STEP)
	) else $error("result is not read value minus one");

	AST_ACC_DEST: assert property ( // see RULE2
		(take && i_dest == DEST_ACC) |-> ##3 (o_acc_wr_en && !o_mem_wr_en)
	) else $error("accumulator destination not honoured");

	AST_FILE_DEST: assert property ( // see RULE3
		(take && i_dest == DEST_FILE) |-> ##3 (o_mem_wr_en && !o_acc_wr_en)
	) else $error("file destination not honoured");

	AST_ZERO_SKIP: assert property ( // see RULE4
		(state_r == ST_EXEC && op_r == OP_DEC_SKIP_ZERO
			&& i_mem_rdata == DEC_STEP)
		|=> o_squash ##1 (o_idle_slot && o_done) ##1 o_ready
	) else $error("zero result did not squash next fetch");

	AST_ZERO_NOSKIP: assert property ( // see RULE4
		(state_r == ST_EXEC && op_r == OP_DEC_SKIP_ZERO
			&& i_mem_rdata != DEC_STEP)
		|=> (!o_squash && o_done) ##1 o_ready
	) else $error("nonzero result squashed next fetch");

	AST_SHARED_BANK: assert property ( // see RULE5
		(take && i_bank_sel == BANK_SHARED)
		|=> (o_mem_addr == {SHARED_BANK, $past(i_faddr)})
	) else $error("shared bank not addressed");

	AST_POINTER_BANK: assert property ( // see RULE6
		(take && i_bank_sel == BANK_POINTER)
		|=> (o_mem_addr == {$past(i_bank_pointer), $past(i_faddr)})
	) else $error("bank pointer not used for address");

	AST_NONZERO_SKIP: assert property ( // see RULE7
		(state_r == ST_EXEC && op_r == OP_DEC_SKIP_NONZERO)
		|=> (o_squash == (o_wdata != ZERO_BYTE))
	) else $error("nonzero variant squash decision wrong");

	// a result never lands in both places at once
	AST_WRITE_EXCLUSIVE: assert property ( // see RULE2
		!(o_mem_wr_en && o_acc_wr_en)
	) else $error("result written to both destinations");

	// write-back goes to the address formed at issue
	AST_ADDR_HELD: assert property ( // see RULE3
		!take |=> $stable(o_mem_addr)
	) else $error("data address moved without an issue");

	// squash retires through exactly one idle slot
	AST_SQUASH_RETIRES: assert property ( // see RULE4
		o_squash |-> !o_done ##1 (o_idle_slot && o_done)
	) else $error("squashed fetch not replaced by one idle slot");

	COV_ZERO_SKIP: cover property (
		take && i_op == OP_DEC_SKIP_ZERO ##3 o_squash
	);
	COV_NONZERO_SKIP: cover property (
		take && i_op == OP_DEC_SKIP_NONZERO ##3 o_squash
	);
	COV_ACC_NOSKIP: cover property (o_acc_wr_en && !o_squash);
	COV_BACK_TO_BACK: cover property (o_done ##1 take);
endmodule

`default_nettype wire

/* hdl/dsz_pkg.sv */
// Operation
// RULE1: read file register, subtract one, yield result
// RULE2: destination bit 0 writes result to accumulator
// RULE3: destination bit 1 writes result back to register
// RULE4: zero result squashes next fetch, idle slot
// RULE5: bank bit 0 selects shared low bank
// RULE6: bank bit 1 uses bank pointer for address
// RULE7: nonzero variant squashes on nonzero result instead
`timescale 1ns/100ps
`default_nettype none

package dsz_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8; // file register width
	localparam int FADDR_W = 8; // in-bank offset width
	localparam int BANK_W = 4; // bank pointer width
	localparam int MADDR_W = FADDR_W + BANK_W; // full data address

	// ----------------------------------------------------------------
	// operand encodings and constants
	// ----------------------------------------------------------------
	localparam logic DEST_ACC = 1'b0; // result to accumulator
	localparam logic DEST_FILE = 1'b1; // result back to file register
	localparam logic BANK_SHARED = 1'b0; // shared low bank
	localparam logic BANK_POINTER = 1'b1; // bank from bank pointer
	localparam logic [BANK_W-1:0] SHARED_BANK = 4'h0; // shared bank num
	localparam logic [DATA_W-1:0] DEC_STEP = 8'h01; // decrement amount
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00; // zero result

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// which decrement flavour was decoded
	typedef enum logic {
		OP_DEC_SKIP_ZERO = 1'b0, // dec_skip_zero
		OP_DEC_SKIP_NONZERO = 1'b1 // dec_skip_nonzero
	} dsz_op_t;

	// execution sequence
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, // waiting for an issued instruction
		ST_READ = 3'b001, // file register read strobe
		ST_EXEC = 3'b010, // read data back, decrement
		ST_WRITE = 3'b011, // write to destination
		ST_SKIP = 3'b100 // idle_slot in place of squashed fetch
	} dsz_state_t;
endpackage

// --------------------------------------------------------------------
// decrement datapath
// --------------------------------------------------------------------
module dsz_dec_unit (
	input wire logic [dsz_pkg::DATA_W-1:0] i_value, // operand read
	output logic [dsz_pkg::DATA_W-1:0] o_result, // operand minus one
	output logic o_zero // result is zero
);
	import dsz_pkg::*;

	// subtract one, wrapping 0 to all ones
	always_comb begin
		o_result = i_value - DEC_STEP; // see RULE1
		o_zero = (o_result == ZERO_BYTE);
	end
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import dsz_pkg::*;
	// ----------------------------------------------------------------
	// signals and dut
	// ----------------------------------------------------------------
	logic i_mclk, i_rst_n, i_issue, i_dest, i_bank_sel; // stimulus
	dsz_op_t i_op; // decoded flavour
	logic [FADDR_W-1:0] i_faddr; // operand f
	logic [BANK_W-1:0] i_bank_pointer; // bank register
	logic [DATA_W-1:0] i_mem_rdata; // memory read data
	logic o_ready, o_mem_rd_en, o_mem_wr_en, o_acc_wr_en; // handshakes
	logic o_squash, o_idle_slot, o_done; // sequence strobes
	logic [MADDR_W-1:0] o_mem_addr; // data address
	logic [DATA_W-1:0] o_wdata; // result
	int bad_count = 0; // mismatches
	int num_checks = 0; // comparisons

	dsz_core i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_issue(i_issue),
		.i_op(i_op), .i_faddr(i_faddr), .i_dest(i_dest),
		.i_bank_sel(i_bank_sel), .i_bank_pointer(i_bank_pointer),
		.i_mem_rdata(i_mem_rdata), .o_ready(o_ready),
		.o_mem_rd_en(o_mem_rd_en), .o_mem_addr(o_mem_addr),
		.o_mem_wr_en(o_mem_wr_en), .o_acc_wr_en(o_acc_wr_en),
		.o_wdata(o_wdata), .o_squash(o_squash),
		.o_idle_slot(o_idle_slot), .o_done(o_done));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask

	// verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// issue one instruction, play the memory, judge every strobe
	task automatic exec_op(input dsz_op_t op, input logic [7:0] f,
		input logic d, input logic a, input logic [3:0] bp,
		input logic [7:0] v);
		logic [7:0] res;
		logic skip;
		logic [11:0] ea;
		int rc, wc, sq, ic, dc, rd;
		res = v - 8'h01;
		skip = (op == OP_DEC_SKIP_ZERO) ? (res == 8'h00) : (res != 8'h00);
		ea = {(a ? bp : SHARED_BANK), f};
		rc = 99;
		wc = 99;
		sq = 99;
		ic = 99;
		dc = 99;
		rd = 0;
		chk(o_ready, 1);
		i_op = op;
		i_faddr = f;
		i_dest = d;
		i_bank_sel = a;
		i_bank_pointer = bp;
		i_issue = 1'b1;
		@(posedge i_mclk);
		#1;
		// operands only count at the take edge
		i_issue = 1'b0;
		i_faddr = ~f;
		i_dest = ~d;
		i_bank_sel = ~a;
		i_bank_pointer = ~bp;
		for (int c = 1; c <= 8; c++) begin
			if (o_mem_rd_en === 1'b1) begin
				rd++;
				rc = c;
				chk(o_mem_addr, ea);
				i_mem_rdata = v;
			end
			// read data no longer held after its window
			if (c == rc + 2)
				i_mem_rdata = ~v;
			if (o_mem_wr_en === 1'b1 || o_acc_wr_en === 1'b1) begin
				wc = c;
				chk(o_wdata, res);
				chk(o_mem_wr_en, d);
				chk(o_acc_wr_en, !d);
				if (d)
					chk(o_mem_addr, ea);
			end
			if (o_squash === 1'b1)
				sq = c;
			if (o_idle_slot === 1'b1)
				ic = c;
			if (o_done === 1'b1)
				dc = c;
			chk(o_ready, dc < c);
			if (o_ready === 1'b1)
				break;
			@(posedge i_mclk);
			#1;
		end
		chk(rd, 1);
		chk(rc, 1);
		chk(wc, 3);
		chk(sq, skip ? 3 : 99);
		chk(ic, skip ? 4 : 99);
		chk(dc, skip ? 4 : 3);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// result to file via bank pointer, then accumulator via shared bank
	task automatic s_dest_bank;
		exec_op(OP_DEC_SKIP_ZERO, 8'h3c, 1'b1, 1'b1, 4'h5, 8'h10);
		exec_op(OP_DEC_SKIP_ZERO, 8'hff, 1'b0, 1'b0, 4'h9, 8'h42);
		exec_op(OP_DEC_SKIP_ZERO, 8'h00, 1'b1, 1'b1, 4'hf, 8'h81);
	endtask

	// zero result squashes, back to back, wrap does not
	task automatic s_skip_zero;
		exec_op(OP_DEC_SKIP_ZERO, 8'h07, 1'b1, 1'b0, 4'h3, 8'h01);
		exec_op(OP_DEC_SKIP_ZERO, 8'h07, 1'b0, 1'b1, 4'h3, 8'h01);
		exec_op(OP_DEC_SKIP_ZERO, 8'h80, 1'b1, 1'b1, 4'ha, 8'h00);
	endtask

	// nonzero flavour squashes on nonzero and on wrap
	task automatic s_skip_nonzero;
		exec_op(OP_DEC_SKIP_NONZERO, 8'h11, 1'b1, 1'b1, 4'h2, 8'h01);
		exec_op(OP_DEC_SKIP_NONZERO, 8'h22, 1'b0, 1'b0, 4'h6, 8'h00);
		exec_op(OP_DEC_SKIP_NONZERO, 8'h33, 1'b1, 1'b1, 4'hc, 8'h80);
	endtask

	// ----------------------------------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	initial begin
		i_rst_n = 1'b0;
		i_issue = 1'b0;
		i_op = OP_DEC_SKIP_ZERO;
		i_faddr = 8'h00;
		i_dest = 1'b1;
		i_bank_sel = 1'b1;
		i_bank_pointer = 4'h0;
		i_mem_rdata = 8'h5a;
		repeat (8) @(posedge i_mclk);
		#1 i_rst_n = 1'b1;
		s_dest_bank();
		s_skip_zero();
		s_skip_nonzero();
		report_and_stop();
	end

	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
endmodule

`default_nettype wire
